// ==== include/swatch_pkg.sv ====
`default_nettype none
package swatch_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STAT_OFF = 8'h04;
   localparam logic [7:0] MASK_OFF = 8'h08;
   localparam logic [7:0] TIME_OFF = 8'h0C;
   localparam logic [7:0] CAP2_OFF = 8'h10;
   // Status bit positions
   localparam int ST_CAP2 = 0;
   localparam int ST_RESUME = 1;
   localparam int ST_HALTED = 8;
   localparam int ST_PIN = 9;
   localparam int ST_VALID = 10;
   localparam int CTRL_W = 14;
   // Field encodings
   localparam logic [1:0] FN_INPUT = 2'h3;
   localparam logic [2:0] CAP2_LAST = 3'h5;
   localparam logic [1:0] IRQA_PIN = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Timing
   localparam real CLK_MHZ = 100.0;
   localparam real TBASE_KHZ = 8.192;
   localparam real SAMPLE_PERIOD_MS = 62.5;
   localparam int TBASE_CYC = int'(CLK_MHZ * 1000.0 / TBASE_KHZ - 0.5);
   localparam int SAMPLE_CYC = int'(SAMPLE_PERIOD_MS * CLK_MHZ * 1000.0);

   typedef struct packed {
      logic [1:0] irq_a_pin_function;
      logic [2:0] capture2_mode;
      logic [1:0] event_pin_function_sel;
      logic event_capture_enable;
      logic event_pin_polarity;
      logic switch_detect_select;
      logic pin_halt_enable;
      logic irq_level_or_pulse_a;
      logic capture_irq_enable_a;
      logic soft_halt;
   } ctrl_t;

   typedef struct packed {
      ctrl_t ctrl;
      logic [1:0] stat;
      logic [1:0] mask;
      logic [31:0] time_cnt;
      logic [31:0] capture_reg_2;
      logic [31:0] tb_cnt;
      logic [31:0] smp_cnt;
      logic smp_valid;
      logic smp_pin;
      logic irq_pulse;
      logic aw_done;
      logic w_done;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_t;

   localparam ctrl_t CTRL_RST = '0;
   localparam state_t STATE_RST = '0;
endpackage
`default_nettype wire

// ==== src/swatch_capture.sv ====
// What this block does
// R1: Each sampled pin event copies the time into capture register 2 and signals output A; a soft halt does not block the capture.
// R2: Sampler is invalid until switch mode is on, then needs one full period.
// R3: Software should enable switch mode 62.5 ms before enabling event capture.
// R4: Event pin function value 11 makes the event pin an input.
// R5: Switch-detect select at 1 puts the sampler into switch detection.
// R6: Polarity bit at 1 makes a low level the active pin state.
// R7: Pin-halt enable at 1 lets the active pin halt counting.
// R8: Capture interrupt enable for A at 1 lets captures interrupt.
// R9: Capture-2 mode 101 records the latest event, overwriting older values.
// R10: Interrupt-A pin function 10 routes interrupt A to its pin.
// R11: A pin change does nothing until a sample shows the new level.
// R12: With active-low polarity a sampled high-to-low change is an event.
// R13: With pin-halt and active low, counting halts while sampled pin is low.
// R14: On the event capture register 2 loads the time and its flag sets.
// R15: With level/pulse select 0 a capture pulses output A.
// R16: Sampled high again releases the halt and counting resumes.
// R17: Halt is the software halt bit or the enabled active pin.
// R18: Halt gates the 8.192 kHz time base and freezes the counter.
// R19: Event, capture, flag and halt all act on the detecting sample tick.
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module swatch_capture #(
   parameter int TBASE_CYCLES = swatch_pkg::TBASE_CYC,
   parameter int SAMPLE_CYCLES = swatch_pkg::SAMPLE_CYC
) (
   input wire logic I_MCLK,
   input wire logic I_SYS_RST,
   input wire logic I_CE,
   input wire logic I_EVENT_INPUT_PIN,
   output logic O_EVENT_PULLUP_EN,
   output logic O_IRQ_A_N,
   output logic O_IRQ,
   input wire logic [7:0] I_AWADDR,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   output logic O_WREADY,
   output logic [1:0] O_BRESP,
   output logic O_BVALID,
   input wire logic I_BREADY,
   input wire logic [7:0] I_ARADDR,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_RVALID,
   input wire logic I_RREADY
);
   swatch_pkg::state_t q;
   swatch_pkg::state_t d;
   logic smp_en;
   logic smp_tick;
   logic eff_pin;
   logic eff_valid;
   logic act_old;
   logic act_new;
   logic event_now;
   logic release_now;
   logic halt;
   logic tb_tick;
   logic capture;
   logic aw_hs;
   logic w_hs;
   logic ar_hs;
   logic do_write;
   logic [1:0] st_set;
   logic [1:0] st_clr;
   logic [31:0] status_word;
   logic [31:0] tb_next;
   logic [31:0] time_next;
   logic [31:0] ctrl_merged;
   logic [31:0] time_merged;
   logic wsel_ctrl;
   logic wsel_stat;
   logic wsel_mask;
   logic wsel_time;
   logic wsel_cap2;
   logic wsel_none;
   logic rsel_ctrl;
   logic rsel_stat;
   logic rsel_mask;
   logic rsel_time;
   logic rsel_cap2;
   logic rsel_none;
   logic [31:0] rd_word;
   logic [1:0] rd_resp;
   logic [31:0] ctrl_word;
   logic [31:0] mask_word;
   logic pin_active;
   logic pin_halt;

   // Byte-lane merge of a write into an old register value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Active-state test of a pin level
   function automatic logic is_active(input logic lvl, input logic pol);
      return lvl ^ pol;
   endfunction

   // R4: input mode pin
   // R5: switch detection mode
   assign smp_en = q.ctrl.switch_detect_select && (q.ctrl.event_pin_function_sel == swatch_pkg::FN_INPUT);
   assign O_EVENT_PULLUP_EN = smp_en;
   // R11: sample tick only
   assign smp_tick = smp_en && (q.smp_cnt == 32'(SAMPLE_CYCLES - 1));
   // R19: same tick view
   always_comb begin
      eff_pin = q.smp_pin;
      eff_valid = smp_en && q.smp_valid;
      if (smp_tick) begin
         eff_pin = I_EVENT_INPUT_PIN;
         eff_valid = 1'b1;
      end
   end

   // R6: polarity select
   assign act_old = is_active(q.smp_pin, q.ctrl.event_pin_polarity);
   assign act_new = is_active(I_EVENT_INPUT_PIN, q.ctrl.event_pin_polarity);
   // R2: wait for valid
   // R12: sampled edge event
   always_comb begin
      event_now = 1'b0;
      release_now = 1'b0;
      if (smp_tick && q.smp_valid) begin
         event_now = !act_old && act_new && q.ctrl.event_capture_enable;
         release_now = act_old && !act_new;
      end
   end
   assign pin_active = is_active(eff_pin, q.ctrl.event_pin_polarity);
   // R7: pin halt enable
   // R13: hold while active
   // R16: release on inactive
   assign pin_halt = q.ctrl.pin_halt_enable && eff_valid && pin_active;
   // R17: halt combination
   assign halt = q.ctrl.soft_halt || pin_halt;
   assign tb_tick = (q.tb_cnt == 32'(TBASE_CYCLES - 1));

   always_comb begin
      tb_next = q.tb_cnt + 32'h00000001;
      if (tb_tick) begin
         tb_next = 32'h00000000;
      end
   end
   // R18: gated time base
   always_comb begin
      time_next = q.time_cnt;
      if (tb_tick && !halt) begin
         time_next = q.time_cnt + 32'h00000001;
      end
   end
   // R9: last event mode
   assign capture = event_now && (q.ctrl.capture2_mode == swatch_pkg::CAP2_LAST);

   assign aw_hs = I_AWVALID && O_AWREADY;
   assign w_hs = I_WVALID && O_WREADY;
   assign ar_hs = I_ARVALID && O_ARREADY;
   // Readies drop while frozen or while an answer is pending
   always_comb begin
      O_AWREADY = 1'b0;
      O_WREADY = 1'b0;
      O_ARREADY = 1'b0;
      if (I_CE) begin
         O_AWREADY = !q.aw_done && !q.bvalid;
         O_WREADY = !q.w_done && !q.bvalid;
         O_ARREADY = !q.rvalid;
      end
   end
   assign O_BVALID = q.bvalid;
   assign O_BRESP = q.bresp;
   assign O_RVALID = q.rvalid;
   assign O_RDATA = q.rdata;
   assign O_RRESP = q.rresp;

   assign status_word = {21'h000000, q.smp_valid, q.smp_pin, halt, 6'h00, q.stat};
   assign O_IRQ = |(q.stat & q.mask);

   assign ctrl_word = {18'h00000, q.ctrl};
   assign mask_word = {30'h00000000, q.mask};
   // Lane-merged write data for the control and time registers
   assign ctrl_merged = merge(ctrl_word, q.wdata, q.wstrb);
   assign time_merged = merge(q.time_cnt, q.wdata, q.wstrb);

   // Write decode from the address held since the AW take
   always_comb begin
      wsel_ctrl = 1'b0;
      wsel_stat = 1'b0;
      wsel_mask = 1'b0;
      wsel_time = 1'b0;
      wsel_cap2 = 1'b0;
      wsel_none = 1'b0;
      if (q.waddr == swatch_pkg::CTRL_OFF) begin
         wsel_ctrl = 1'b1;
      end else if (q.waddr == swatch_pkg::STAT_OFF) begin
         wsel_stat = 1'b1;
      end else if (q.waddr == swatch_pkg::MASK_OFF) begin
         wsel_mask = 1'b1;
      end else if (q.waddr == swatch_pkg::TIME_OFF) begin
         wsel_time = 1'b1;
      end else if (q.waddr == swatch_pkg::CAP2_OFF) begin
         wsel_cap2 = 1'b1;
      end else begin
         wsel_none = 1'b1;
      end
   end

   // Read decode straight from the request address
   always_comb begin
      rsel_ctrl = 1'b0;
      rsel_stat = 1'b0;
      rsel_mask = 1'b0;
      rsel_time = 1'b0;
      rsel_cap2 = 1'b0;
      rsel_none = 1'b0;
      if (I_ARADDR == swatch_pkg::CTRL_OFF) begin
         rsel_ctrl = 1'b1;
      end else if (I_ARADDR == swatch_pkg::STAT_OFF) begin
         rsel_stat = 1'b1;
      end else if (I_ARADDR == swatch_pkg::MASK_OFF) begin
         rsel_mask = 1'b1;
      end else if (I_ARADDR == swatch_pkg::TIME_OFF) begin
         rsel_time = 1'b1;
      end else if (I_ARADDR == swatch_pkg::CAP2_OFF) begin
         rsel_cap2 = 1'b1;
      end else begin
         rsel_none = 1'b1;
      end
   end

   // Unmapped words read zero with an error response
   always_comb begin
      rd_word = 32'h00000000;
      rd_resp = swatch_pkg::RESP_OKAY;
      if (rsel_ctrl) begin
         rd_word = ctrl_word;
      end else if (rsel_stat) begin
         rd_word = status_word;
      end else if (rsel_mask) begin
         rd_word = mask_word;
      end else if (rsel_time) begin
         rd_word = q.time_cnt;
      end else if (rsel_cap2) begin
         rd_word = q.capture_reg_2;
      end else if (rsel_none) begin
         rd_resp = swatch_pkg::RESP_SLVERR;
      end
   end

   // R1: capture on pin event
   // R14: load and flag
   always_comb begin
      st_set = 2'h0;
      if (capture) begin
         st_set[swatch_pkg::ST_CAP2] = 1'b1;
      end
      if (release_now) begin
         st_set[swatch_pkg::ST_RESUME] = 1'b1;
      end
   end

   // R10: route to pin
   // R15: pulse or level
   always_comb begin
      logic lvl;
      logic routed;
      lvl = 1'b0;
      routed = 1'b0;
      if (q.ctrl.irq_level_or_pulse_a) begin
         lvl = q.stat[swatch_pkg::ST_CAP2] && q.ctrl.capture_irq_enable_a;
      end else begin
         lvl = q.irq_pulse;
      end
      if (q.ctrl.irq_a_pin_function == swatch_pkg::IRQA_PIN) begin
         routed = 1'b1;
      end
      O_IRQ_A_N = !(lvl && routed);
   end

   always_comb begin
      d = q;
      st_clr = 2'h0;
      do_write = 1'b0;
      if (I_CE) begin
         // Sampler: cleared while disabled so stale data never counts
         if (!smp_en) begin
            d.smp_cnt = 32'h00000000;
            d.smp_valid = 1'b0;
         end else if (smp_tick) begin
            d.smp_cnt = 32'h00000000;
            d.smp_pin = I_EVENT_INPUT_PIN;
            d.smp_valid = 1'b1;
         end else begin
            d.smp_cnt = q.smp_cnt + 32'h00000001;
         end

         // Prescaler keeps running; only its ticks are gated
         d.tb_cnt = tb_next;
         d.time_cnt = time_next;

         // R14: time into capture register
         if (capture) begin
            d.capture_reg_2 = q.time_cnt;
         end
         // R8: capture interrupt enable
         d.irq_pulse = capture && q.ctrl.capture_irq_enable_a;

         // Write channel
         if (aw_hs) begin
            d.aw_done = 1'b1;
            d.waddr = I_AWADDR;
         end
         if (w_hs) begin
            d.w_done = 1'b1;
            d.wdata = I_WDATA;
            d.wstrb = I_WSTRB;
         end
         if (q.bvalid && I_BREADY) begin
            d.bvalid = 1'b0;
         end
         do_write = q.aw_done && q.w_done && !q.bvalid;
         if (do_write) begin
            d.aw_done = 1'b0;
            d.w_done = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = swatch_pkg::RESP_OKAY;
            if (wsel_ctrl) begin
               d.ctrl = swatch_pkg::ctrl_t'(ctrl_merged[swatch_pkg::CTRL_W-1:0]);
            end else if (wsel_stat) begin
               if (q.wstrb[0]) begin
                  st_clr = q.wdata[1:0];
               end
            end else if (wsel_mask) begin
               if (q.wstrb[0]) begin
                  d.mask = q.wdata[1:0];
               end
            end else if (wsel_time) begin
               d.time_cnt = time_merged;
            end else if (wsel_cap2) begin
               d.bresp = swatch_pkg::RESP_OKAY;
            end else if (wsel_none) begin
               d.bresp = swatch_pkg::RESP_SLVERR;
            end
         end
         // Set wins over a clear in the same cycle
         d.stat = (q.stat & ~st_clr) | st_set;

         // Read channel
         if (q.rvalid && I_RREADY) begin
            d.rvalid = 1'b0;
         end
         if (ar_hs) begin
            d.rvalid = 1'b1;
            d.rdata = rd_word;
            d.rresp = rd_resp;
         end
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         q <= swatch_pkg::STATE_RST;
      end else begin
         q <= d;
      end
   end
endmodule
`default_nettype wire

// ==== verif/swatch_capture_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module swatch_capture_asserts #(
   parameter int TBASE_CYCLES = 8,
   parameter int SAMPLE_CYCLES = 20
) (
   input wire logic I_MCLK,
   input wire logic I_SYS_RST,
   input wire logic I_CE,
   input wire logic O_IRQ_A_N,
   input wire logic O_IRQ,
   input wire logic I_AWVALID,
   input wire logic O_AWREADY,
   input wire logic I_WVALID,
   input wire logic O_WREADY,
   input wire logic O_BVALID,
   input wire logic [1:0] O_BRESP,
   input wire logic I_BREADY,
   input wire logic [7:0] I_ARADDR,
   input wire logic I_ARVALID,
   input wire logic O_ARREADY,
   input wire logic O_RVALID,
   input wire logic [31:0] O_RDATA,
   input wire logic [1:0] O_RRESP,
   input wire logic I_RREADY
);
   logic [15:0] gap_q;
   logic [15:0] gap_d;
   // Cycles since the interrupt pin was last low
   assign gap_d = (!O_IRQ_A_N) ? 16'h0 : gap_q + {15'h0, gap_q != 16'hFFFF};
   always_ff @(posedge I_MCLK) begin
      gap_q <= I_SYS_RST ? 16'h0 : gap_d;
   end
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (I_SYS_RST);
   property p_rst_idle; $fell(I_SYS_RST) |-> O_IRQ_A_N && !O_IRQ && !O_BVALID && !O_RVALID; endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("outputs busy after reset");
   property p_irq_pulse; $fell(O_IRQ_A_N) |=> O_IRQ_A_N; endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq pulse too long");
   property p_irq_gap; $fell(O_IRQ_A_N) |-> gap_q >= SAMPLE_CYCLES; endproperty
   a_irq_gap: assert property (p_irq_gap) else $error("irq off the sample ticks");
   property p_b_hold; O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold; O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read response dropped");
   property p_w_answer; I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID; endproperty
   a_w_answer: assert property (p_w_answer) else $error("write response late");
   property p_r_unmap; I_ARVALID && O_ARREADY && I_ARADDR > 8'h10
      |=> O_RVALID && O_RRESP == swatch_pkg::RESP_SLVERR && O_RDATA == 32'h0; endproperty
   a_r_unmap: assert property (p_r_unmap) else $error("unmapped read not refused");
   property p_wr_refuse; O_BVALID || !I_CE |-> !O_AWREADY && !O_WREADY; endproperty
   a_wr_refuse: assert property (p_wr_refuse) else $error("write taken while busy");
   property p_rd_refuse; O_RVALID || !I_CE |-> !O_ARREADY; endproperty
   a_rd_refuse: assert property (p_rd_refuse) else $error("read taken while busy");
endmodule
bind swatch_capture swatch_capture_asserts #(.TBASE_CYCLES(TBASE_CYCLES), .SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
   .I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST), .I_CE(I_CE), .O_IRQ_A_N(O_IRQ_A_N), .O_IRQ(O_IRQ),
   .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
   .O_BVALID(O_BVALID), .O_BRESP(O_BRESP), .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR),
   .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID), .O_RDATA(O_RDATA),
   .O_RRESP(O_RRESP), .I_RREADY(I_RREADY));
`default_nettype wire

// ==== verif/switch_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module switch_model (
   input wire logic i_clk,
   input wire logic i_closed,
   input wire logic i_pullup_en,
   output logic o_pin
);
   logic flt_q = 1'b0;
   always_ff @(posedge i_clk) flt_q <= !flt_q;
   // Closed shorts to ground; open without pull-up floats
   assign o_pin = i_closed ? 1'b0 : (i_pullup_en ? 1'b1 : flt_q);
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int SC = 20;
   localparam int TB = 8;
   logic clk, rst, ce, closed, awvalid, wvalid, bready, arvalid, rready;
   logic pin, pu, irq_n, irq, awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata_o, rv, t0, t1;
   logic [1:0] bresp_o, rresp_o, rsp;
   int n_errors = 0;
   int checked = 0;
   swatch_capture #(.TBASE_CYCLES(TB), .SAMPLE_CYCLES(SC)) u_swatch_capture (.I_MCLK(clk), .I_SYS_RST(rst),
      .I_CE(ce), .I_EVENT_INPUT_PIN(pin), .O_EVENT_PULLUP_EN(pu), .O_IRQ_A_N(irq_n), .O_IRQ(irq),
      .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF),
      .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp_o), .O_BVALID(bvalid), .I_BREADY(bready),
      .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata_o), .O_RRESP(rresp_o),
      .O_RVALID(rvalid), .I_RREADY(rready));
   switch_model u_switch_model (.i_clk(clk), .i_closed(closed), .i_pullup_en(pu), .o_pin(pin));
   function automatic logic [31:0] cfg(input logic cap, input logic hlt);
      return {18'h0, swatch_pkg::IRQA_PIN, swatch_pkg::CAP2_LAST, swatch_pkg::FN_INPUT, cap, 5'h1D, hlt};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w;
      aw = 0;
      w = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(posedge clk);
         aw = aw | awready;
         w = w | wready;
         awvalid <= !aw;
         wvalid <= !w;
      end while (!(aw && w));
      do @(posedge clk); while (bvalid !== 1'b1);
      r = bresp_o;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      rv = rdata_o;
      rsp = rresp_o;
      rready <= 1'b0;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   initial begin
      #500000;
      n_errors++;
      tally_and_finish;
   end
   initial begin
      {rst, ce} = 2'h3;
      {closed, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      rv = $urandom(69880);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(swatch_pkg::CTRL_OFF);
      chk("ctrl_rst", 32'h0, rv);
      rd(8'h20);
      chk("unmapped_rd", {30'h0, swatch_pkg::RESP_SLVERR}, {30'h0, rsp});
      wr(8'h24, $urandom, rsp);
      chk("unmapped_wr", {30'h0, swatch_pkg::RESP_SLVERR}, {30'h0, rsp});
      wr(swatch_pkg::CAP2_OFF, $urandom, rsp);
      rd(swatch_pkg::CAP2_OFF);
      chk("cap2_ro", 32'h0, rv);
      $display("test reset done");
      wr(swatch_pkg::CTRL_OFF, cfg(1'b0, 1'b0), rsp);
      wr(swatch_pkg::MASK_OFF, 32'h3, rsp);
      rd(swatch_pkg::CTRL_OFF);
      chk("ctrl", cfg(1'b0, 1'b0), rv);
      chk("pullup", 32'h1, {31'h0, pu});
      repeat (2 * SC) @(posedge clk);
      rd(swatch_pkg::STAT_OFF);
      chk("smp_valid", 32'h1, {31'h0, rv[swatch_pkg::ST_VALID]});
      chk("smp_pin", 32'h1, {31'h0, rv[swatch_pkg::ST_PIN]});
      wr(swatch_pkg::CTRL_OFF, cfg(1'b1, 1'b0), rsp);
      for (int i = 0; i < 3; i++) begin
         repeat ($urandom_range(3 * SC, 5)) @(posedge clk);
         closed <= 1'b1;
         for (int k = 0; k < 4 * SC && irq_n !== 1'b0; k++) @(posedge clk);
         chk("irq_a_n", 32'h0, {31'h0, irq_n});
         rd(swatch_pkg::TIME_OFF);
         t0 = rv;
         repeat (3 * TB) @(posedge clk);
         rd(swatch_pkg::TIME_OFF);
         chk("time_halted", t0, rv);
         rd(swatch_pkg::CAP2_OFF);
         chk("cap2", t0, rv);
         rd(swatch_pkg::STAT_OFF);
         chk("halted", 32'h1, {31'h0, rv[swatch_pkg::ST_HALTED]});
         chk("irq", 32'h1, {31'h0, irq});
         closed <= 1'b0;
         repeat (2 * SC + 3 * TB) @(posedge clk);
         rd(swatch_pkg::TIME_OFF);
         chk("time_runs", 32'h1, {31'h0, rv > t0});
         rd(swatch_pkg::STAT_OFF);
         chk("stat_set", 32'h3, {30'h0, rv[1:0]});
         wr(swatch_pkg::STAT_OFF, 32'h3, rsp);
         rd(swatch_pkg::STAT_OFF);
         chk("stat_clr", 32'h0, {30'h0, rv[1:0]});
         chk("irq_clr", 32'h0, {31'h0, irq});
         $display("test event %0d done", i);
      end
      wr(swatch_pkg::CTRL_OFF, cfg(1'b1, 1'b1), rsp);
      rd(swatch_pkg::TIME_OFF);
      t1 = rv;
      repeat (3 * TB) @(posedge clk);
      rd(swatch_pkg::TIME_OFF);
      chk("soft_halt", t1, rv);
      $display("test soft halt done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
